//--- rtl/ras_defines.vh
`ifndef RAS_DEFINES_VH
`define RAS_DEFINES_VH

// Widths
`define RAS_PC_W        21
`define RAS_SP_W        5
`define RAS_DEPTH       31

// Program space
`define RAS_PC_RESET    21'h000000
`define RAS_VEC_HIGH    21'h000008
`define RAS_VEC_LOW     21'h000018
`define RAS_PC_STEP     21'h000002
`define RAS_IMPL_BYTES  21'h002000
`define RAS_NOP_WORD    16'h0000

// Register byte offsets
`define RAS_OFS_PTR     8'h00
`define RAS_OFS_TOP_ENTRY_LOW    8'h04
`define RAS_OFS_TOP_ENTRY_HIGH    8'h08
`define RAS_OFS_TOP_ENTRY_UPPER    8'h0C
`define RAS_OFS_LATH    8'h10
`define RAS_OFS_LATU    8'h14
`define RAS_OFS_CTRL    8'h18
`define RAS_OFS_PC      8'h1C

// Pointer register fields
`define RAS_PTR_FULL    7
`define RAS_PTR_UNF     6
`define RAS_SP_ZERO     5'h00
`define RAS_SP_ONE      5'h01
`define RAS_SP_LAST     5'h1F
`define RAS_SP_PREV     5'h1E

// Control register fields
`define RAS_CTL_OVR     0
`define RAS_CTL_PUSH    1
`define RAS_CTL_POP     2
`define RAS_CTL_RESET   1'b1

// AHB encodings
`define RAS_HTRANS_NSEQ 2'h2
`define RAS_HTRANS_SEQ  2'h3
`define RAS_HRESP_OKAY  1'b0

`endif

//--- rtl/ras_return_stack.v
`timescale 1ns/1ps
`include "ras_defines.vh"

// Functional notes
// RULE1: Program counter is 21 bits, 2-Mbyte space
// RULE2: Fetch beyond implemented memory returns zeros
// RULE3: Reset vector 0000h, interrupt vectors 0008h/0018h
// RULE4: Up to 31 nested calls and interrupts
// RULE5: Push PC on call or interrupt acknowledge
// RULE6: Pop into PC on any return
// RULE7: Calls and returns leave PC latches alone
// RULE8: 31 entries of 21 bits, 5-bit pointer
// RULE9: Every reset clears the stack pointer
// RULE10: Pointer zero means empty, no entry
// RULE11: Push increments pointer, then writes entry
// RULE12: Pop reads entry, then decrements pointer
// RULE13: Stack reachable only via pointer and top registers
// RULE14: Software reads/writes pointer, pushes and pops
// RULE15: Top registers access entry selected by pointer
// RULE16: Flags show full, overflow, underflow
// RULE17: Software masks interrupts while touching stack
// RULE18: Interrupt wake-up pushes PC then loads vector
// RULE19: Program and data buses are separate
// RULE20: Overflow reset on: store, flag, reset device
// RULE21: Overflow reset off: pointer stays 31, no overwrite
// RULE22: Empty pop loads zero, sets underflow flag
// RULE23: Pointer reg: bit7 full, bit6 underflow, bit5 zero
// RULE24: Pointer write precedes next stack operation
module ras_return_stack (
  input  wire        CLK,        // Core clock, 200 MHz
  input  wire        RST,        // Any reset, sync, active high
  input  wire        POR,        // Power-on reset, sync, active high
  input  wire        HSEL,       // AHB slave select
  input  wire [31:0] HADDR,      // AHB address
  input  wire [1:0]  HTRANS,     // AHB transfer type
  input  wire        HWRITE,     // AHB write
  input  wire [2:0]  HSIZE,      // AHB size, word only
  input  wire [31:0] HWDATA,     // AHB write data
  input  wire        HREADY,     // AHB bus ready
  output wire        HREADYOUT,  // AHB slave ready
  output reg  [31:0] HRDATA,     // AHB read data
  output wire        HRESP,      // AHB response, always OKAY
  input  wire        OP_CALL,    // Call executes, pulse
  input  wire [20:0] CALL_TARGET,// Call destination
  input  wire        OP_RET,     // Any return executes, pulse
  input  wire        OP_IRQ,     // Interrupt acknowledge, pulse
  input  wire        IRQ_HIGH,   // 1: high-priority vector
  input  wire        OP_STEP,    // Advance to next instruction
  output wire [20:0] PM_ADDR,    // Program bus address
  input  wire [15:0] PM_RDATA,   // Program bus raw data
  output reg  [15:0] FETCH_WORD, // Fetched word, zero past memory
  output reg         STACK_RESET // Stack reset request, pulse
);

  reg  [20:0] stk_mem [1:`RAS_DEPTH];
  reg  [20:0] pc_r;
  reg  [20:0] pc_nxt;
  reg  [4:0]  sp_r;
  reg  [4:0]  sp_nxt;
  reg         full_r;
  reg         full_nxt;
  reg         unf_r;
  reg         unf_nxt;
  reg  [7:0]  lath_r;
  reg  [4:0]  latu_r;
  reg         ovr_en_r;
  reg         rst_req_nxt;
  reg         mem_we;
  reg  [4:0]  mem_wa;
  reg  [20:0] mem_wd;
  reg         dph_r;
  reg         dph_wr_r;
  reg  [7:0]  dph_ofs_r;
  reg  [4:0]  sp_eff;
  reg  [20:0] tos_val;
  reg  [20:0] tos_wr;
  reg         do_push;
  reg         do_pop;
  reg         pop_load;
  reg  [20:0] push_val;
  reg  [20:0] vec_val;
  reg  [4:0]  sp_aft;
  reg  [20:0] pc_aft;
  reg  [20:0] tos_aft;
  reg         full_aft;
  reg         unf_aft;
  reg  [7:0]  lath_nxt;
  reg  [4:0]  latu_nxt;
  reg         ovr_en_nxt;
  reg         rd_go;
  reg  [7:0]  rd_ofs;
  reg  [31:0] hrdata_nxt;
  wire        core_op;
  wire        bus_go;
  wire        bus_wr;
  wire        addr_ok;

  assign core_op   = OP_CALL | OP_RET | OP_IRQ;
  // Stall the bus data phase while the core touches the stack, so a
  // software access always lands between core operations, never inside.
  assign HREADYOUT = ~(dph_r & core_op);
  assign HRESP     = `RAS_HRESP_OKAY;
  assign bus_go    = dph_r & ~core_op;
  assign bus_wr    = bus_go & dph_wr_r;
  assign addr_ok   = HSEL & HREADY & (HTRANS == `RAS_HTRANS_NSEQ ||
                     HTRANS == `RAS_HTRANS_SEQ);
  // RULE19: separate program bus
  assign PM_ADDR   = pc_r;

  // Address phase capture
  always @(posedge CLK) begin
    if (RST) begin
      dph_r     <= 1'b0;
      dph_wr_r  <= 1'b0;
      dph_ofs_r <= 8'h00;
    end else if (HREADYOUT) begin
      dph_r     <= addr_ok;
      dph_wr_r  <= addr_ok & HWRITE;
      dph_ofs_r <= HADDR[7:0];
    end
  end

  // RULE24: new pointer seen at once
  always @* begin
    sp_eff = sp_r;
    if (bus_wr && dph_ofs_r == `RAS_OFS_PTR)
      sp_eff = HWDATA[4:0];
  end

  // RULE15: top entry follows pointer
  // RULE10: pointer zero has no entry
  always @* begin
    if (sp_r == `RAS_SP_ZERO)
      tos_val = `RAS_PC_RESET;
    else
      tos_val = stk_mem[sp_r];
  end

  // RULE3: vector select
  always @* begin
    if (IRQ_HIGH)
      vec_val = `RAS_VEC_HIGH;
    else
      vec_val = `RAS_VEC_LOW;
  end

  // Stack sequencing
  always @* begin
    pc_nxt      = pc_r;
    sp_nxt      = sp_eff;
    full_nxt    = full_r;
    unf_nxt     = unf_r;
    rst_req_nxt = 1'b0;
    mem_we      = 1'b0;
    mem_wa      = sp_eff;
    mem_wd      = pc_r;
    do_push     = 1'b0;
    do_pop      = 1'b0;
    pop_load    = 1'b0;
    push_val    = pc_r;
    tos_wr      = tos_val;
    // RULE5: push on call or interrupt
    // RULE18: interrupt saves PC, then vectors
    if (OP_IRQ) begin
      do_push = 1'b1;
      pc_nxt  = vec_val;
    end else if (OP_CALL) begin
      do_push = 1'b1;
      pc_nxt  = {CALL_TARGET[20:1], 1'b0};
    end else if (OP_RET) begin
      // RULE6: pop into PC
      do_pop   = 1'b1;
      pop_load = 1'b1;
    end else if (bus_wr && dph_ofs_r == `RAS_OFS_CTRL) begin
      // RULE14: software push and pop
      do_push = HWDATA[`RAS_CTL_PUSH];
      do_pop  = HWDATA[`RAS_CTL_POP] & ~HWDATA[`RAS_CTL_PUSH];
    end else if (OP_STEP) begin
      pc_nxt = pc_r + `RAS_PC_STEP;
    end
    if (bus_wr) begin
      case (dph_ofs_r)
        `RAS_OFS_TOP_ENTRY_LOW: tos_wr = {tos_val[20:8], HWDATA[7:0]};
        `RAS_OFS_TOP_ENTRY_HIGH: tos_wr = {tos_val[20:16], HWDATA[7:0],
                                 tos_val[7:0]};
        `RAS_OFS_TOP_ENTRY_UPPER: tos_wr = {HWDATA[4:0], tos_val[15:0]};
        default:       tos_wr = tos_val;
      endcase
      // RULE13: entry written only via top registers
      if ((dph_ofs_r == `RAS_OFS_TOP_ENTRY_LOW || dph_ofs_r == `RAS_OFS_TOP_ENTRY_HIGH ||
           dph_ofs_r == `RAS_OFS_TOP_ENTRY_UPPER) && sp_r != `RAS_SP_ZERO) begin
        mem_we = 1'b1;
        mem_wa = sp_r;
        mem_wd = tos_wr;
      end
      // RULE23: flags clear-only
      if (dph_ofs_r == `RAS_OFS_PTR) begin
        full_nxt = full_r & HWDATA[`RAS_PTR_FULL];
        unf_nxt  = unf_r & HWDATA[`RAS_PTR_UNF];
      end
    end
    // RULE4: 31-deep nesting limit
    if (do_push) begin
      // RULE21: no overwrite at 31
      if (sp_eff == `RAS_SP_LAST) begin
        full_nxt = 1'b1;
        if (ovr_en_r) begin
          rst_req_nxt = 1'b1;
          sp_nxt      = `RAS_SP_ZERO;
          pc_nxt      = `RAS_PC_RESET;
        end
      end else begin
        // RULE11: increment, then write
        sp_nxt = sp_eff + `RAS_SP_ONE;
        mem_we = 1'b1;
        mem_wa = sp_eff + `RAS_SP_ONE;
        mem_wd = push_val;
        // RULE16: full flag
        if (sp_eff == `RAS_SP_PREV) begin
          full_nxt = 1'b1;
          // RULE20: overflow reset
          if (ovr_en_r) begin
            rst_req_nxt = 1'b1;
            sp_nxt      = `RAS_SP_ZERO;
            pc_nxt      = `RAS_PC_RESET;
          end
        end
      end
    end else if (do_pop) begin
      if (sp_eff == `RAS_SP_ZERO) begin
        // RULE22: empty pop
        unf_nxt = 1'b1;
        if (pop_load)
          pc_nxt = `RAS_PC_RESET;
        if (ovr_en_r) begin
          rst_req_nxt = 1'b1;
          pc_nxt      = `RAS_PC_RESET;
        end
      end else begin
        // RULE12: read, then decrement
        if (pop_load)
          pc_nxt = stk_mem[sp_eff];
        sp_nxt = sp_eff - `RAS_SP_ONE;
      end
    end
  end

  // RULE8: 31 by 21-bit storage
  always @(posedge CLK) begin
    if (mem_we && mem_wa != `RAS_SP_ZERO)
      stk_mem[mem_wa] <= mem_wd;
  end

  always @(posedge CLK) begin
    if (RST) begin
      // RULE9: pointer cleared by reset
      sp_r        <= `RAS_SP_ZERO;
      // RULE3: start at reset vector
      pc_r        <= `RAS_PC_RESET;
      STACK_RESET <= 1'b0;
    end else begin
      sp_r        <= sp_nxt;
      // RULE1: 21-bit word-aligned PC
      pc_r        <= {pc_nxt[20:1], 1'b0};
      STACK_RESET <= rst_req_nxt;
    end
  end

  // Flags survive every reset but power-on; set beats clear
  always @(posedge CLK) begin
    if (POR) begin
      full_r <= 1'b0;
      unf_r  <= 1'b0;
    end else begin
      full_r <= full_nxt;
      unf_r  <= unf_nxt;
    end
  end

  // RULE7: latches change only by software writes and reset
  always @* begin
    lath_nxt   = lath_r;
    latu_nxt   = latu_r;
    ovr_en_nxt = ovr_en_r;
    if (RST) begin
      lath_nxt   = 8'h00;
      latu_nxt   = 5'h00;
      ovr_en_nxt = `RAS_CTL_RESET;
    end else if (bus_wr) begin
      if (dph_ofs_r == `RAS_OFS_LATH)
        lath_nxt = HWDATA[7:0];
      if (dph_ofs_r == `RAS_OFS_LATU)
        latu_nxt = HWDATA[4:0];
      if (dph_ofs_r == `RAS_OFS_CTRL)
        ovr_en_nxt = HWDATA[`RAS_CTL_OVR];
    end
  end

  always @(posedge CLK) begin
    lath_r   <= lath_nxt;
    latu_r   <= latu_nxt;
    ovr_en_r <= ovr_en_nxt;
  end

  // RULE2: zeros past implemented memory
  always @(posedge CLK) begin
    if (RST)
      FETCH_WORD <= `RAS_NOP_WORD;
    else if (pc_r >= `RAS_IMPL_BYTES)
      FETCH_WORD <= `RAS_NOP_WORD;
    else
      FETCH_WORD <= PM_RDATA;
  end

  // Read data is loaded from the state as it stands after this edge, so a
  // data phase stalled by a core op still returns the freshest value.
  always @* begin
    sp_aft   = RST ? `RAS_SP_ZERO : sp_nxt;
    pc_aft   = RST ? `RAS_PC_RESET : {pc_nxt[20:1], 1'b0};
    full_aft = POR ? 1'b0 : full_nxt;
    unf_aft  = POR ? 1'b0 : unf_nxt;
    if (sp_aft == `RAS_SP_ZERO)
      tos_aft = `RAS_PC_RESET;
    else if (mem_we && mem_wa == sp_aft)
      tos_aft = mem_wd;
    else
      tos_aft = stk_mem[sp_aft];
    rd_go  = HREADYOUT ? (addr_ok & ~HWRITE) : (dph_r & ~dph_wr_r);
    rd_ofs = HREADYOUT ? HADDR[7:0] : dph_ofs_r;
    hrdata_nxt = 32'h00000000;
    if (rd_go && !RST) begin
      case (rd_ofs)
        `RAS_OFS_PTR:
          hrdata_nxt = {24'h000000, full_aft, unf_aft, 1'b0, sp_aft};
        `RAS_OFS_TOP_ENTRY_LOW: hrdata_nxt = {24'h000000, tos_aft[7:0]};
        `RAS_OFS_TOP_ENTRY_HIGH: hrdata_nxt = {24'h000000, tos_aft[15:8]};
        `RAS_OFS_TOP_ENTRY_UPPER: hrdata_nxt = {27'h0000000, tos_aft[20:16]};
        `RAS_OFS_LATH: hrdata_nxt = {24'h000000, lath_nxt};
        `RAS_OFS_LATU: hrdata_nxt = {27'h0000000, latu_nxt};
        `RAS_OFS_CTRL: hrdata_nxt = {31'h00000000, ovr_en_nxt};
        `RAS_OFS_PC:   hrdata_nxt = {11'h000, pc_aft};
        default:       hrdata_nxt = 32'h00000000;
      endcase
    end
  end

  always @(posedge CLK) begin
    if (RST)
      HRDATA <= 32'h00000000;
    else
      HRDATA <= hrdata_nxt;
  end

endmodule // ras_return_stack

//--- dv/ras_return_stack_props.sv
`timescale 1ns/1ps
module ras_return_stack_props (
  input wire        CLK,         // Core clock
  input wire        RST,         // Reset
  input wire        HREADYOUT,   // Slave ready
  input wire        HSEL,        // Select
  input wire [1:0]  HTRANS,      // Transfer type
  input wire        HWRITE,      // Write
  input wire        OP_CALL,     // Call
  input wire [20:0] CALL_TARGET, // Call target
  input wire        OP_RET,      // Return
  input wire        OP_IRQ,      // Interrupt
  input wire        IRQ_HIGH,    // Vector select
  input wire        OP_STEP,     // Step
  input wire [20:0] PM_ADDR,     // Program address
  input wire [15:0] PM_RDATA,    // Raw word
  input wire [15:0] FETCH_WORD,  // Fetched word
  input wire        STACK_RESET  // Reset request
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_pulse;
    STACK_RESET ##1 !STACK_RESET;
  endsequence
  // Zero is allowed too: an overflowing push resets the program counter
  a_irq_high_vec: assert property (OP_IRQ && IRQ_HIGH |=>
    PM_ADDR == 21'h000008 || PM_ADDR == 21'h000000) else $error("bad vector");
  a_irq_low_vec: assert property (OP_IRQ && !IRQ_HIGH |=>
    PM_ADDR == 21'h000018 || PM_ADDR == 21'h000000) else $error("bad vector");
  a_call_target: assert property (OP_CALL && !OP_IRQ |=>
    PM_ADDR == ($past(CALL_TARGET) & 21'h1FFFFE) || PM_ADDR == 21'h000000)
    else $error("call target lost");
  a_step_pc: assert property (OP_STEP && !OP_CALL && !OP_RET && !OP_IRQ &&
    !$past(HSEL && HTRANS[1] && HWRITE) |=> PM_ADDR == $past(PM_ADDR) + 21'h000002)
    else $error("step wrong");
  a_fetch_blank: assert property (PM_ADDR >= 21'h002000 |=>
    FETCH_WORD == 16'h0000) else $error("fetch not blanked");
  // Reset zeroes the fetched word, so edges sampled in reset are skipped
  a_fetch_pass: assert property (!RST && PM_ADDR < 21'h002000 |=>
    FETCH_WORD == $past(PM_RDATA)) else $error("fetch word wrong");
  a_reset_pc: assert property (@(posedge CLK) disable iff (1'b0) RST |=>
    PM_ADDR == 21'h000000 && !STACK_RESET) else $error("reset pc wrong");
  a_reset_pulse: assert property ($rose(STACK_RESET) |-> s_pulse)
    else $error("reset pulse too long");
  a_ready_idle: assert property (!OP_CALL && !OP_RET && !OP_IRQ |->
    HREADYOUT) else $error("bus stalled");
endmodule // ras_return_stack_props
bind ras_return_stack ras_return_stack_props ras_return_stack_props_i (
  .CLK, .RST, .HREADYOUT, .HSEL, .HTRANS, .HWRITE, .OP_CALL, .CALL_TARGET,
  .OP_RET, .OP_IRQ, .IRQ_HIGH, .OP_STEP, .PM_ADDR, .PM_RDATA, .FETCH_WORD,
  .STACK_RESET);

//--- dv/ras_prog_mem.sv
`timescale 1ns/1ps
module ras_prog_mem (
  input  wire [20:0] pm_addr,  // Fetch address
  output wire [15:0] pm_rdata  // Raw word
);
  // own program bus
  // Never zero, so missing blanking past memory shows
  assign pm_rdata = {pm_addr[15:1] ^ 15'h5A5A, 1'b1};
endmodule // ras_prog_mem

//--- dv/ras_return_stack_test.sv
`timescale 1ns/1ps
module ras_return_stack_test;
  typedef struct {logic [2:0] k; logic [20:0] t, pc; logic [4:0] sp;
                  logic [20:0] tos;} ras_row_t;
  reg         CLK, RST, POR, HSEL, HWRITE, OP_CALL, OP_RET, OP_IRQ;
  reg         IRQ_HIGH, OP_STEP, rst_seen;
  reg  [31:0] HADDR, HWDATA, rd;
  reg  [1:0]  HTRANS;
  reg  [2:0]  HSIZE;
  reg  [20:0] CALL_TARGET, x;
  wire        HREADYOUT, HRESP, STACK_RESET;
  wire [31:0] HRDATA;
  wire [20:0] PM_ADDR;
  wire [15:0] PM_RDATA, FETCH_WORD;
  integer     miscompares = 0, checks_done = 0, cycles = 0, i;
  ras_row_t   rows [8] = '{'{1, 21'h100, 21'h100, 1, 0},
    '{1, 21'h1FFFFF, 21'h1FFFFE, 2, 21'h100}, '{2, 0, 21'h8, 3, 21'h1FFFFE},
    '{3, 0, 21'h18, 4, 21'h8}, '{4, 0, 21'h8, 3, 21'h1FFFFE},
    '{4, 0, 21'h1FFFFE, 2, 21'h100}, '{4, 0, 21'h100, 1, 0}, '{4, 0, 0, 0, 0}};
  ras_return_stack ras_return_stack_i (.CLK, .RST, .POR, .HSEL, .HADDR,
    .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY(HREADYOUT), .HREADYOUT,
    .HRDATA, .HRESP, .OP_CALL, .CALL_TARGET, .OP_RET, .OP_IRQ, .IRQ_HIGH,
    .OP_STEP, .PM_ADDR, .PM_RDATA, .FETCH_WORD, .STACK_RESET);
  ras_prog_mem ras_prog_mem_i (.pm_addr(PM_ADDR), .pm_rdata(PM_RDATA));
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares = miscompares + 1;
      end_of_test;
    end
  end
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input string n, input [31:0] e, input [31:0] g);
    checks_done = checks_done + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Entered just after an edge; holds each phase until ready is sampled
  task bus(input w, input [7:0] a, input [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {24'h0, a};
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    rd = HRDATA;
  endtask
  task rdc(input [7:0] a, input [31:0] e, input string n);
    bus(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task tos(input [20:0] e);
    bus(1'b0, 8'h04, 32'h0);
    x[7:0] = rd[7:0];
    bus(1'b0, 8'h08, 32'h0);
    x[15:8] = rd[7:0];
    bus(1'b0, 8'h0C, 32'h0);
    x[20:16] = rd[4:0];
    chk("top", {11'h0, e}, {11'h0, x});
  endtask
  // Kinds: 1 call, 2 high irq, 3 low irq, 4 return
  task op(input [2:0] k, input [20:0] t);
    OP_CALL <= k == 1;
    OP_IRQ <= k == 2 || k == 3;
    IRQ_HIGH <= k == 2;
    OP_RET <= k == 4;
    CALL_TARGET <= t;
    @(posedge CLK);
    OP_CALL <= 1'b0;
    OP_IRQ <= 1'b0;
    OP_RET <= 1'b0;
    rst_seen = 1'b0;
    repeat (3) begin
      @(posedge CLK);
      rst_seen = rst_seen | STACK_RESET;
    end
  endtask
  initial begin
    {RST, POR, HSEL, HWRITE, OP_CALL, OP_RET, OP_IRQ, IRQ_HIGH} = 8'hC0;
    {OP_STEP, HADDR, HWDATA, HTRANS, CALL_TARGET} = 0;
    HSIZE = 3'h2;
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    POR <= 1'b0;
    @(posedge CLK);
    rdc(8'h00, 32'h0, "ptr");
    rdc(8'h18, 32'h1, "ctrl");
    chk("hresp", 32'h0, {31'h0, HRESP});
    chk("pc", 32'h0, {11'h0, PM_ADDR});
    bus(1'b1, 8'h10, 32'hAB);
    bus(1'b1, 8'h14, 32'h15);
    for (i = 0; i < 8; i = i + 1) begin
      op(rows[i].k, rows[i].t);
      chk("pc", {11'h0, rows[i].pc}, {11'h0, PM_ADDR});
      rdc(8'h00, {27'h0, rows[i].sp}, "ptr");
      tos(rows[i].tos);
    end
    rdc(8'h10, 32'hAB, "lath");
    rdc(8'h14, 32'h15, "latu");
    op(3'd4, 21'h0);
    chk("unf_rst", 32'h1, {31'h0, rst_seen});
    rdc(8'h00, 32'h40, "ptr");
    bus(1'b1, 8'h00, 32'hE5);
    rdc(8'h00, 32'h45, "ptr");
    bus(1'b1, 8'h18, 32'h3);
    rdc(8'h00, 32'h46, "ptr");
    bus(1'b1, 8'h04, 32'h5A);
    tos(21'h5A);
    bus(1'b1, 8'h18, 32'h5);
    rdc(8'h00, 32'h45, "ptr");
    bus(1'b1, 8'h20, 32'hFFFF);
    rdc(8'h20, 32'h0, "unmapped");
    bus(1'b1, 8'h18, 32'h0);
    bus(1'b1, 8'h00, 32'h1D);
    op(3'd1, 21'h200);
    op(3'd1, 21'h300);
    op(3'd1, 21'h400);
    rdc(8'h00, 32'h9F, "ptr");
    tos(21'h200);
    bus(1'b1, 8'h18, 32'h1);
    bus(1'b1, 8'h00, 32'h1E);
    op(3'd2, 21'h0);
    chk("ovf_rst", 32'h1, {31'h0, rst_seen});
    rdc(8'h00, 32'h80, "ptr");
    op(3'd1, 21'h2000);
    chk("fetch", 32'h0, {16'h0, FETCH_WORD});
    op(3'd1, 21'h1FFE);
    chk("fetch", 32'hAB4B, {16'h0, FETCH_WORD});
    rdc(8'h1C, 32'h1FFE, "pc_rd");
    OP_STEP <= 1'b1;
    @(posedge CLK);
    OP_STEP <= 1'b0;
    @(posedge CLK);
    chk("step", 32'h2000, {11'h0, PM_ADDR});
    RST <= 1'b1;
    @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    rdc(8'h00, 32'h80, "ptr");
    RST <= 1'b1;
    POR <= 1'b1;
    @(posedge CLK);
    RST <= 1'b0;
    POR <= 1'b0;
    @(posedge CLK);
    rdc(8'h00, 32'h0, "ptr");
    end_of_test;
  end
endmodule // ras_return_stack_test
